/* File: logic/odsc_regs.svh */
// register field positions and reset values of the octal converter control
`ifndef ODSC_REGS_SVH
`define ODSC_REGS_SVH
`define ODSC_WORD_BITS    16
`define ODSC_TYPE_BIT     15
`define ODSC_ADDR_HI      14
`define ODSC_ADDR_LO      12
`define ODSC_MODE_HI      14
`define ODSC_MODE_LO      13
`define ODSC_RST_ALL_BIT  12
`define ODSC_DATA_HI      11
`define ODSC_SUPPLY_LO    0
`define ODSC_BUF_LO       2
`define ODSC_GAIN_LO      4
`define ODSC_POLICY_RST   2'h1
`define ODSC_CFG_RST      6'h00
`define ODSC_PD_RST       8'h00
`endif

/* File: logic/odsc_pkg.sv */
// types shared by the octal converter control
`default_nettype none
package odsc_pkg;
  typedef enum logic [1:0] {
    ODSC_POL_LOW    = 2'h0,
    ODSC_POL_HIGH   = 2'h1,
    ODSC_POL_SINGLE = 2'h2,
    ODSC_POL_RSVD   = 2'h3
  } odsc_policy_e;
  typedef enum logic [1:0] {
    ODSC_M_REF   = 2'h0,
    ODSC_M_LOAD  = 2'h1,
    ODSC_M_PDOWN = 2'h2,
    ODSC_M_RESET = 2'h3
  } odsc_mode_e;
  typedef enum logic [2:0] {
    ODSC_S_IDLE  = 3'h1,
    ODSC_S_SHIFT = 3'h2,
    ODSC_S_DONE  = 3'h4
  } odsc_state_e;
  // per group setting: supply ref, buffer, gain (index 0 = first group)
  typedef struct packed {
    logic [1:0] gain;
    logic [1:0] buf_en;
    logic [1:0] supply;
  } odsc_cfg_s;
endpackage
`default_nettype wire

/* File: logic/odsc_core.sv */
// serial command receiver and double-buffered register bank of the octal converter
`timescale 1ns/1ps
`default_nettype none
`include "odsc_regs.svh"
module odsc_core #(
  parameter int DATA_BITS = 12
) (
  // clock and reset
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_rst,
  // serial link pins
  input  wire logic                       i_sclk,
  input  wire logic                       i_din,
  input  wire logic                       i_frame_select_n,
  input  wire logic                       i_load_dac_n,
  // converter outputs
  output logic [8*DATA_BITS-1:0]          o_dac_code,
  output logic [7:0]                      o_power_down,
  output odsc_pkg::odsc_cfg_s             o_eff_cfg,
  output odsc_pkg::odsc_policy_e          o_policy,
  output logic                            o_frame_done
);
  import odsc_pkg::*;

  logic [2:0] sclk_sync_reg;
  logic [1:0] din_sync_reg;
  logic [1:0] fs_sync_reg;
  logic [1:0] ld_sync_reg;
  logic       din_s;
  logic       fs_n_s;
  logic       ld_n_s;
  logic       sclk_fall;

  // first stage is read only by the second
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      sclk_sync_reg <= 3'h0;
      din_sync_reg  <= 2'h0;
      fs_sync_reg   <= 2'h3;
      ld_sync_reg   <= 2'h3;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], i_sclk};
      din_sync_reg  <= {din_sync_reg[0], i_din};
      fs_sync_reg   <= {fs_sync_reg[0], i_frame_select_n};
      ld_sync_reg   <= {ld_sync_reg[0], i_load_dac_n};
    end
  end
  // sclk carries a spare stage that holds the previous sample for falling-edge detection; the edge is seen with the same delay as data
  assign din_s     = din_sync_reg[1];
  assign fs_n_s    = fs_sync_reg[1];
  assign ld_n_s    = ld_sync_reg[1];
  assign sclk_fall = sclk_sync_reg[2] & ~sclk_sync_reg[1];

  // frame receiver
  odsc_state_e state_reg;
  logic [`ODSC_WORD_BITS-1:0] shift_reg;
  logic [4:0]                 count_reg;
  logic                       word_valid;
  logic [`ODSC_WORD_BITS-1:0] word;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      state_reg <= ODSC_S_IDLE;
      shift_reg <= 16'h0000;
      count_reg <= 5'h00;
    end else begin
      case (state_reg)
        ODSC_S_IDLE: begin
          count_reg <= 5'h00;
          if (!fs_n_s) begin
            state_reg <= ODSC_S_SHIFT;
          end
        end
        ODSC_S_SHIFT: begin
          if (fs_n_s) begin
            state_reg <= ODSC_S_IDLE;
          end else if (sclk_fall) begin
            shift_reg <= {shift_reg[`ODSC_WORD_BITS-2:0], din_s};
            count_reg <= count_reg + 5'h01;
            if (count_reg == 5'h0F) begin
              state_reg <= ODSC_S_DONE;
            end
          end
        end
        ODSC_S_DONE: begin
          // further clocks are ignored until select rises
          if (fs_n_s) begin
            state_reg <= ODSC_S_IDLE;
          end
        end
        default: state_reg <= ODSC_S_IDLE;
      endcase
    end
  end

  // decode once, in the cycle that sees the sixteenth falling edge
  assign word_valid = (state_reg == ODSC_S_SHIFT) && !fs_n_s && sclk_fall && (count_reg == 5'h0F);
  assign word       = {shift_reg[`ODSC_WORD_BITS-2:0], din_s};

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_frame_done <= 1'b0;
    end else begin
      o_frame_done <= word_valid;
    end
  end

  // register bank
  logic [DATA_BITS-1:0] in_reg [8];
  logic [7:0]           dirty_reg;
  odsc_cfg_s            cfg_in_reg;
  logic                 cfg_dirty_reg;
  odsc_cfg_s            cfg_out_reg;
  logic                 single_reg;
  logic                 is_data;
  logic                 is_ctrl;
  odsc_mode_e           mode;
  logic [2:0]           addr;
  logic                 load_now;
  logic                 data_clear;
  logic                 ctrl_clear;

  assign is_data    = word_valid && !word[`ODSC_TYPE_BIT];
  assign is_ctrl    = word_valid && word[`ODSC_TYPE_BIT];
  assign mode       = odsc_mode_e'(word[`ODSC_MODE_HI:`ODSC_MODE_LO]);
  assign addr       = word[`ODSC_ADDR_HI:`ODSC_ADDR_LO];
  assign data_clear = is_ctrl && (mode == ODSC_M_RESET);
  assign ctrl_clear = data_clear && word[`ODSC_RST_ALL_BIT];
  // pin low or policy low keeps outputs transparent
  assign load_now   = !ld_n_s || (o_policy == ODSC_POL_LOW) || single_reg;

  // control registers
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || ctrl_clear) begin
      o_policy     <= odsc_policy_e'(`ODSC_POLICY_RST);
      o_power_down <= `ODSC_PD_RST;
      cfg_in_reg   <= `ODSC_CFG_RST;
      single_reg   <= 1'b0;
    end else begin
      single_reg <= 1'b0;
      if (is_ctrl && mode == ODSC_M_REF) begin
        cfg_in_reg <= word[5:0];
      end
      if (is_ctrl && mode == ODSC_M_LOAD) begin
        // reserved code leaves the policy alone
        if (word[1:0] == ODSC_POL_SINGLE) begin
          single_reg <= 1'b1;
        end else if (word[1:0] != ODSC_POL_RSVD) begin
          o_policy <= odsc_policy_e'(word[1:0]);
        end
      end
      if (is_ctrl && mode == ODSC_M_PDOWN) begin
        o_power_down <= word[7:0];
      end
    end
  end

  // gain, buffer and supply settings follow the same load path
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || ctrl_clear) begin
      cfg_dirty_reg <= 1'b0;
      cfg_out_reg   <= `ODSC_CFG_RST;
    end else if (load_now && cfg_dirty_reg) begin
      cfg_out_reg   <= cfg_in_reg;
      cfg_dirty_reg <= is_ctrl && mode == ODSC_M_REF;
    end else if (is_ctrl && mode == ODSC_M_REF) begin
      cfg_dirty_reg <= 1'b1;
    end
  end

  // supply reference wins over buffer and gain per group
  always_comb begin
    o_eff_cfg.supply = cfg_out_reg.supply;
    o_eff_cfg.buf_en = cfg_out_reg.buf_en & ~cfg_out_reg.supply;
    o_eff_cfg.gain   = cfg_out_reg.gain & ~cfg_out_reg.supply;
  end

  genvar ch;
  generate
    for (ch = 0; ch < 8; ch++) begin : g_chan
      logic [DATA_BITS-1:0] out_reg;
      logic                 wr;
      assign wr = is_data && (addr == 3'(ch));
      always_ff @(posedge i_ref_clk) begin
        if (i_rst || data_clear) begin
          in_reg[ch] <= '0;
        end else if (wr) begin
          // narrow variants drop the low bits of the field
          in_reg[ch] <= word[`ODSC_DATA_HI -: DATA_BITS];
        end
      end
      // dirty tracking saves needless reloads; a write in the load cycle stays pending
      always_ff @(posedge i_ref_clk) begin
        if (i_rst || data_clear) begin
          dirty_reg[ch] <= 1'b0;
          out_reg       <= '0;
        end else if (load_now && dirty_reg[ch]) begin
          out_reg       <= in_reg[ch];
          dirty_reg[ch] <= wr;
        end else if (wr) begin
          dirty_reg[ch] <= 1'b1;
        end
      end
      assign o_dac_code[ch*DATA_BITS +: DATA_BITS] = out_reg;
    end
  endgenerate

  // write capture used only by the checks below
  logic [2:0]           wr_addr_reg;
  logic [DATA_BITS-1:0] wr_data_reg;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wr_addr_reg <= 3'h0;
      wr_data_reg <= '0;
    end else if (is_data) begin
      wr_addr_reg <= addr;
      wr_data_reg <= word[`ODSC_DATA_HI -: DATA_BITS];
    end
  end

  sequence s_data_write;
    is_data && !data_clear;
  endsequence
  sequence s_pin_low;
    !ld_n_s;
  endsequence

  property p_write_lands;
    @(posedge i_ref_clk) disable iff (i_rst)
      s_data_write |=> (in_reg[wr_addr_reg] == wr_data_reg) && dirty_reg[wr_addr_reg];
  endproperty
  a_write_lands: assert property (p_write_lands) else $error("channel write not captured");

  property p_sync_load;
    @(posedge i_ref_clk) disable iff (i_rst)
      s_data_write ##1 s_pin_low |=> o_dac_code[wr_addr_reg*DATA_BITS +: DATA_BITS] == wr_data_reg;
  endproperty
  a_sync_load: assert property (p_sync_load) else $error("pin low did not load new word");

  property p_pin_load;
    @(posedge i_ref_clk) disable iff (i_rst)
      (!ld_n_s && !word_valid) |=> (dirty_reg == 8'h00) && !cfg_dirty_reg;
  endproperty
  a_pin_load: assert property (p_pin_load) else $error("pending loads left while pin low");

  property p_single;
    @(posedge i_ref_clk) disable iff (i_rst)
      (is_ctrl && mode == ODSC_M_LOAD && word[1:0] == ODSC_POL_SINGLE) |=> single_reg ##1 !single_reg;
  endproperty
  a_single: assert property (p_single) else $error("single update pulse wrong");

  property p_policy_set;
    @(posedge i_ref_clk) disable iff (i_rst)
      (is_ctrl && mode == ODSC_M_LOAD && !word[1]) |=> (o_policy == $past(word[1:0]));
  endproperty
  a_policy_set: assert property (p_policy_set) else $error("load policy not applied");

  property p_cfg_hold;
    @(posedge i_ref_clk) disable iff (i_rst)
      (!load_now && !ctrl_clear) |=> $stable(cfg_out_reg);
  endproperty
  a_cfg_hold: assert property (p_cfg_hold) else $error("settings changed without load");

  property p_cfg_write;
    @(posedge i_ref_clk) disable iff (i_rst)
      (is_ctrl && mode == ODSC_M_REF) |=> (cfg_in_reg == $past(word[5:0])) && cfg_dirty_reg;
  endproperty
  a_cfg_write: assert property (p_cfg_write) else $error("reference setup not captured");

  property p_abort;
    @(posedge i_ref_clk) disable iff (i_rst)
      (state_reg == ODSC_S_SHIFT && fs_n_s) |-> ##1 (state_reg == ODSC_S_IDLE && !o_frame_done);
  endproperty
  a_abort: assert property (p_abort) else $error("aborted frame not discarded");

  sequence s_valid_word;
    word_valid;
  endsequence
  property p_done;
    @(posedge i_ref_clk) disable iff (i_rst)
      s_valid_word |=> o_frame_done ##1 !o_frame_done;
  endproperty
  a_done: assert property (p_done) else $error("frame done pulse wrong");

  property p_latched;
    @(posedge i_ref_clk) disable iff (i_rst)
      (ld_n_s && o_policy == ODSC_POL_HIGH && !single_reg && !data_clear) |=> $stable(o_dac_code);
  endproperty
  a_latched: assert property (p_latched) else $error("outputs changed while latched");

  property p_data_reset;
    @(posedge i_ref_clk) disable iff (i_rst)
      data_clear |=> (o_dac_code == '0) && (dirty_reg == 8'h00);
  endproperty
  a_data_reset: assert property (p_data_reset) else $error("data reset failed");

  property p_full_reset;
    @(posedge i_ref_clk) disable iff (i_rst)
      ctrl_clear |=> (o_policy == ODSC_POL_HIGH) && (o_power_down == 8'h00) && (o_eff_cfg == '0);
  endproperty
  a_full_reset: assert property (p_full_reset) else $error("control reset failed");

  property p_pdown;
    @(posedge i_ref_clk) disable iff (i_rst)
      (is_ctrl && mode == ODSC_M_PDOWN && !ctrl_clear) |=> (o_power_down == $past(word[7:0]));
  endproperty
  a_pdown: assert property (p_pdown) else $error("power-down bits not applied");

  property p_supply_prio;
    @(posedge i_ref_clk) disable iff (i_rst)
      ((o_eff_cfg.gain | o_eff_cfg.buf_en) & o_eff_cfg.supply) == 2'h0;
  endproperty
  a_supply_prio: assert property (p_supply_prio) else $error("supply reference not unity unbuffered");

  property p_transparent;
    @(posedge i_ref_clk) disable iff (i_rst)
      (is_data && o_policy == ODSC_POL_LOW && !data_clear) |-> ##2
        (o_dac_code[wr_addr_reg*DATA_BITS +: DATA_BITS] == wr_data_reg) || !(o_policy == ODSC_POL_LOW);
  endproperty
  a_transparent: assert property (p_transparent) else $error("transparent update missing");
endmodule
`default_nettype wire

/* File: testbench/odsc_host.sv */
// serial host model that drives command frames into the converter control
`timescale 1ns/1ps
`default_nettype none
module odsc_host (
  // reference clock used to pace the link
  input  wire logic i_ref_clk,
  // serial link pins
  output logic      o_sclk,
  output logic      o_din,
  output logic      o_frame_select_n
);
  initial begin
    o_sclk           = 1'b1;
    o_din            = 1'b0;
    o_frame_select_n = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(negedge i_ref_clk);
  endtask
  // half period of 4 reference cycles gives the 200 ns link clock
  // nfall below 16 cuts the frame short on purpose
  task automatic send(input logic [15:0] word, input int nfall);
    o_frame_select_n = 1'b0;
    wait_clk(4);
    for (int i = 15; i > 15 - nfall; i--) begin
      o_din = word[i];
      wait_clk(4);
      o_sclk = 1'b0;
      wait_clk(4);
      o_sclk = 1'b1;
    end
    wait_clk(4);
    o_frame_select_n = 1'b1;
    // released data line must not keep its last value
    o_din = ~o_din;
    wait_clk(8);
  endtask
endmodule
`default_nettype wire

/* File: testbench/octal_dac_serial_control_tb.sv */
// self-checking testbench of the octal converter control
`timescale 1ns/1ps
`default_nettype none
module octal_dac_serial_control_tb;
  import odsc_pkg::*;
  logic          i_ref_clk;
  logic          i_rst;
  logic          i_load_dac_n;
  logic          sclk;
  logic          din;
  logic          fsel_n;
  logic [95:0]   code;
  logic [7:0]    pdown;
  odsc_cfg_s     eff;
  odsc_policy_e  pol;
  logic          done;
  logic [95:0]   exp_code;
  int            err_count = 0;
  int            checks_done = 0;
  int            frames = 0;
  int            frames_exp = 0;
  logic [5:0]    cfg_tab [3] = '{6'h3C, 6'h3D, 6'h3E};
  logic [5:0]    eff_tab [3] = '{6'h3C, 6'h29, 6'h16};

  odsc_host u_host (.i_ref_clk(i_ref_clk), .o_sclk(sclk), .o_din(din), .o_frame_select_n(fsel_n));
  odsc_core #(.DATA_BITS(12)) u_dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sclk(sclk), .i_din(din),
    .i_frame_select_n(fsel_n), .i_load_dac_n(i_load_dac_n), .o_dac_code(code),
    .o_power_down(pdown), .o_eff_cfg(eff), .o_policy(pol), .o_frame_done(done));

  initial begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  always @(negedge i_ref_clk) if (done === 1'b1) frames++;

  task automatic chk(input string what, input logic [95:0] seen, input logic [95:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic put(input logic [15:0] w);
    frames_exp++;
    u_host.send(w, 16);
  endtask
  task automatic wr(input int k, input logic [11:0] v);
    put({1'b0, 3'(k), v});
    exp_code[k*12 +: 12] = v;
  endtask
  task automatic load_pulse();
    i_load_dac_n = 1'b0;
    repeat (6) @(negedge i_ref_clk);
    i_load_dac_n = 1'b1;
    repeat (6) @(negedge i_ref_clk);
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic t_data();
    for (int k = 0; k < 8; k++) wr(k, (k == 7) ? 12'hFFF : 12'(12'h111 * (k + 1)));
    chk("latched codes", code, 96'h0);
    load_pulse();
    chk("loaded codes", code, exp_code);
    u_host.send(16'h1ABC, 15);
    load_pulse();
    chk("aborted frame", code, exp_code);
  endtask
  task automatic t_policy();
    put(16'hA000);
    chk("policy low", pol, 96'h0);
    wr(2, 12'h5A3);
    chk("continuous update", code, exp_code);
    put(16'hA001);
    wr(3, 12'h3C7);
    chk("latched hold", code[47:36], 12'h444);
    put(16'hA002);
    chk("single update", code, exp_code);
    put(16'hA003);
    chk("reserved policy", pol, 96'h1);
    i_load_dac_n = 1'b0;
    wr(4, 12'hABC);
    chk("pin low update", code, exp_code);
    i_load_dac_n = 1'b1;
  endtask
  task automatic t_cfg();
    for (int i = 0; i < 3; i++) begin
      put({10'h200, cfg_tab[i]});
      if (i == 0) chk("cfg before load", eff, 96'h0);
      load_pulse();
      chk("cfg after load", eff, eff_tab[i]);
    end
  endtask
  task automatic t_pdown_reset();
    put(16'hC0A5);
    chk("power down", pdown, 96'hA5);
    wr(0, 12'h777);
    load_pulse();
    chk("write while down", code, exp_code);
    put(16'hE000);
    exp_code = '0;
    chk("data reset codes", code, exp_code);
    chk("data reset keeps pd", pdown, 96'hA5);
    put(16'hA000);
    put(16'hF000);
    chk("full reset pd", pdown, 96'h0);
    chk("full reset policy", pol, 96'h1);
    chk("full reset cfg", eff, 96'h0);
  endtask

  initial begin
    i_rst = 1'b1;
    i_load_dac_n = 1'b1;
    exp_code = '0;
    repeat (5) @(negedge i_ref_clk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_ref_clk);
    chk("reset codes", code, 96'h0);
    chk("reset policy", pol, 96'h1);
    chk("reset cfg", {pdown, eff}, 96'h0);
    t_data();
    t_policy();
    t_cfg();
    t_pdown_reset();
    chk("frame count", frames, frames_exp);
    close_out();
  end
  // a run of about 24 frames needs some 3500 cycles
  initial begin
    repeat (40000) @(posedge i_ref_clk);
    err_count++;
    close_out();
  end
endmodule
`default_nettype wire
